//--- dv/bfl_bank_checker.sv
// concurrent checks on the control bank ports
`timescale 1ns/1ps
`default_nettype none
module bfl_bank_checker (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [3:0] wr_addr,
    input wire logic [5:0] wr_data,
    input wire logic reg_four_enable_pin,
    input wire logic [11:0] regulator_two_mv,
    input wire logic [11:0] regulator_three_mv,
    input wire logic [11:0] regulator_four_mv,
    input wire logic [4:0] sink_on,
    input wire logic [4:0] sink_in_main,
    input wire logic [4:0] main_current_code,
    input wire logic main_ramp_busy,
    input wire logic sub_ramp_busy
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire w_two = wr_en && wr_addr == 4'h6;
    wire w_three = wr_en && wr_addr == 4'h7;
    wire w_fade = wr_en && wr_addr == 4'h9;
    wire w_grp = wr_en && wr_addr == 4'ha;
    wire w_en = wr_en && wr_addr == 4'h0;
    wire w_main = wr_en && wr_addr == 4'h1;
    logic fade_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fade_q <= 1'b0;
        end else if (w_fade) begin
            fade_q <= wr_data[0];
        end
    end
    two_code_a: assert property (
        w_two && wr_data[2:0] == 3'h1 ##1 !w_two |=> regulator_two_mv == 12'h708)
        else $error("regulator two wrong");
    three_code_a: assert property (
        w_three && wr_data[3:0] == 4'hb ##1 !w_three |=> regulator_three_mv == 12'h898)
        else $error("regulator three wrong");
    four_pin_a: assert property (
        !reg_four_enable_pin [*6] |-> regulator_four_mv == 12'h000)
        else $error("regulator four on with pin low");
    main_abort_a: assert property (
        w_fade && !wr_data[0] ##1 !wr_en |=> !main_ramp_busy)
        else $error("main ramp not aborted");
    sub_abort_a: assert property (
        w_fade && !wr_data[3] ##1 !wr_en |=> !sub_ramp_busy)
        else $error("sub ramp not aborted");
    main_direct_a: assert property (
        w_main && !fade_q |-> ##2 main_current_code == 5'($past(wr_data, 2)))
        else $error("main code not applied");
    main_step_a: assert property (
        fade_q && !$past(wr_en) |->
        5'(main_current_code - $past(main_current_code)) inside {5'h00, 5'h01, 5'h1f})
        else $error("main code jumped");
    group_map_a: assert property (
        w_grp && wr_data[2:0] == 3'h4 ##1 !w_grp |=> sink_in_main == 5'h03)
        else $error("group mask wrong");
    sink_enable_a: assert property (
        w_en ##1 !w_en |=> sink_on == 5'($past(wr_data, 2)))
        else $error("sink enables wrong");
endmodule
`default_nettype wire

//--- dv/bfl_host.sv
// host model that writes the control bank over its write port
`timescale 1ns/1ps
`default_nettype none
module bfl_host (
    input wire logic clk,
    output logic wr_en,
    output logic [3:0] wr_addr,
    output logic [5:0] wr_data
);
    initial begin
        wr_en = 1'b0;
        wr_addr = 4'h3;
        wr_data = 6'h2a;
    end
    // write-only bus, one-cycle write strobe per call, nothing read back
    task automatic wr(input logic [3:0] a, input logic [5:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask
endmodule
`default_nettype wire

//--- dv/test_backlight_fade_bank_ldo_regs.sv
// testbench for the control bank
`timescale 1ns/1ps
`default_nettype none
module test_backlight_fade_bank_ldo_regs;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic pin = 1'b1;
    logic we, mb, sb;
    logic [3:0] wa;
    logic [5:0] wd;
    logic [11:0] v2, v3, v4;
    logic [4:0] son, sim, mc, sc, m;
    logic [24:0] scode, e;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #12.5 clk = ~clk;
    bfl_host h (.clk(clk), .wr_en(we), .wr_addr(wa), .wr_data(wd));
    bfl_bank #(.MS_CYCLES(4)) dut (.clk(clk), .arst_n(arst_n), .wr_en(we), .wr_addr(wa),
        .wr_data(wd), .reg_four_enable_pin(pin), .regulator_two_mv(v2),
        .regulator_three_mv(v3), .regulator_four_mv(v4), .sink_on(son),
        .sink_in_main(sim), .sink_code(scode), .main_current_code(mc),
        .sub_current_code(sc), .main_ramp_busy(mb), .sub_ramp_busy(sb));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [24:0] got, input logic [24:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d compares %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    function automatic logic [11:0] wide(input int c);
        if (c == 0) return 12'h000;
        if (c < 11) return 12'(12'hd48 - 12'h064 * c);
        if (c == 11) return 12'h898;
        return 12'(12'h708 - 12'h064 * (c - 12));
    endfunction
    task automatic ramp(input logic [3:0] a, input logic [4:0] c, input int n, ms,
        input logic [5:0] f);
        int t;
        h.wr(a, {1'b0, c});
        if (f != 6'h00) h.wr(4'h9, f);
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while ((a == 4'h1 ? mb : sb) !== 1'b0 && t < 4000);
        chk(25'(t >= (n * ms - 1) * 4 - 2 && t <= n * ms * 4 + 2), 25'h1);
        chk(a == 4'h1 ? mc : sc, c);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        tick(12);
        arst_n <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            h.wr(4'h6, 6'(c));
            tick(3);
            chk(v2, c != 0 ? 12'(12'h76c - 12'h064 * c) : 12'h000);
        end
        for (int c = 0; c < 16; c++) begin
            h.wr(4'h7, 6'(c));
            h.wr(4'h8, 6'(c));
            tick(3);
            chk(v3, wide(c));
            chk(v4, wide(c));
        end
        pin <= 1'b0;
        tick(8);
        chk(v4, 12'h000);
        pin <= 1'b1;
        tick(8);
        chk(v4, wide(15));
        h.wr(4'h6, 6'h39);
        h.wr(4'h7, 6'h31);
        tick(3);
        chk(v2, 12'h708);
        chk(v3, 12'hce4);
        h.wr(4'h0, 6'h1f);
        h.wr(4'h1, 6'h10);
        h.wr(4'h2, 6'h05);
        for (int g = 0; g < 8; g++) begin
            h.wr(4'ha, 6'h38 | 6'(g));
            tick(3);
            m = (g > 0 && g < 6) ? 5'(5'h1f >> (g - 1)) : 5'h1f;
            for (int i = 0; i < 5; i++) e[5*i+:5] = m[i] ? 5'h10 : 5'h05;
            chk(sim, m);
            chk(scode, e);
        end
        h.wr(4'h0, 6'h0a);
        tick(3);
        chk(son, 5'h0a);
        h.wr(4'h9, 6'h07);
        ramp(4'h1, 5'h13, 3, 8, 6'h00);
        h.wr(4'h9, 6'h03);
        ramp(4'h1, 5'h12, 1, 24, 6'h00);
        h.wr(4'h9, 6'h28);
        ramp(4'h2, 5'h07, 2, 16, 6'h00);
        chk(mc, 5'h12);
        h.wr(4'h9, 6'h09);
        ramp(4'h1, 5'h14, 2, 8, 6'h0f);
        h.wr(4'h1, 6'h02);
        tick(40);
        chk(mb, 1'b1);
        h.wr(4'h9, 6'h08);
        tick(2);
        chk(mc, 5'h02);
        h.wr(4'h1, 6'h1f);
        tick(2);
        chk(mc, 5'h1f);
        h.wr(4'h2, 6'h1f);
        tick(40);
        chk(sb, 1'b1);
        h.wr(4'h9, 6'h00);
        tick(2);
        chk(sc, 5'h1f);
        h.wr(4'h9, 6'h1d);
        ramp(4'h1, 5'h1d, 2, 16, 6'h00);
        ramp(4'h2, 5'h1e, 1, 24, 6'h00);
        finish_test();
    end
endmodule
bind bfl_bank bfl_bank_checker chk_i (.clk(clk), .arst_n(arst_n), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .reg_four_enable_pin(reg_four_enable_pin),
    .regulator_two_mv(regulator_two_mv), .regulator_three_mv(regulator_three_mv),
    .regulator_four_mv(regulator_four_mv), .sink_on(sink_on), .sink_in_main(sink_in_main),
    .main_current_code(main_current_code), .main_ramp_busy(main_ramp_busy),
    .sub_ramp_busy(sub_ramp_busy));
`default_nettype wire

//--- src/bfl_bank.sv
// write-only control bank: regulator codes, backlight fade ramps, sink groups
// Summary of operation
// - regulator two 3-bit code: 0 off, 1 is 1.8V, each step 0.1V lower.
// - regulator three 4-bit code: 0 off, 3.3V down to 2.4V, 2.2V, 1.8-1.5V.
// - regulator four uses the same code mapping as regulator three.
// - regulator four is off unless its external enable pin is high.
// - unused upper register bits are written zero and ignored here.
// - main step interval from fade bits 2:1: 32, 24, 16, 8 ms.
// - sub step interval from fade bits 5:4 with the same encoding.
// - main fade enabled: new main code ramps one step per interval.
// - step count equals absolute difference between old and new codes.
// - clearing fade enable mid-ramp applies the target code at once.
// - fade disabled: a new current code applies immediately.
// - rate bits may change anytime; following steps use the new interval.
// - sub fade enabled: sub code ramps independently at the sub interval.
// - group code 1..5 places sinks one-five down to sink one in main.
// - sinks not in main belong to the sub group.
// - main current is a 5-bit code shared by all main sinks; zero is off.
// - each sink conducts only while its enable bit is set.
// - all control registers are write-only; nothing reads back.
`timescale 1ns/1ps
`default_nettype none
module bfl_bank #(
    parameter int MS_CYCLES = bfl_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [bfl_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [bfl_pkg::DATA_W-1:0] wr_data,
    input wire logic reg_four_enable_pin,
    output logic [bfl_pkg::MV_W-1:0] regulator_two_mv,
    output logic [bfl_pkg::MV_W-1:0] regulator_three_mv,
    output logic [bfl_pkg::MV_W-1:0] regulator_four_mv,
    output logic [bfl_pkg::SINKS-1:0] sink_on,
    output logic [bfl_pkg::SINKS-1:0] sink_in_main,
    output logic [bfl_pkg::SINKS*bfl_pkg::CODE_W-1:0] sink_code,
    output logic [bfl_pkg::CODE_W-1:0] main_current_code,
    output logic [bfl_pkg::CODE_W-1:0] sub_current_code,
    output logic main_ramp_busy,
    output logic sub_ramp_busy
);
    localparam int CODE_W = bfl_pkg::CODE_W;
    localparam int SINKS = bfl_pkg::SINKS;
    localparam int TMR_W = bfl_pkg::TMR_W;
    localparam int PRE_W = $clog2(MS_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

    logic [SINKS-1:0] sink_en_q;
    logic [CODE_W-1:0] main_target_q;
    logic [CODE_W-1:0] sub_target_q;
    logic [bfl_pkg::REG_TWO_W-1:0] reg_two_q;
    logic [bfl_pkg::REG_WIDE_W-1:0] reg_three_q;
    logic [bfl_pkg::REG_WIDE_W-1:0] reg_four_q;
    logic main_ramp_enable;
    logic [bfl_pkg::RATE_W-1:0] main_ramp_rate;
    logic sub_ramp_enable;
    logic [bfl_pkg::RATE_W-1:0] sub_ramp_rate;
    logic [bfl_pkg::GROUP_W-1:0] group_code_q;

    // register writes, unused upper bits dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sink_en_q <= '0;
            main_target_q <= '0;
            sub_target_q <= '0;
            reg_two_q <= '0;
            reg_three_q <= '0;
            reg_four_q <= '0;
            main_ramp_enable <= 1'b0;
            main_ramp_rate <= '0;
            sub_ramp_enable <= 1'b0;
            sub_ramp_rate <= '0;
            group_code_q <= '0;
        end else if (wr_en) begin
            case (wr_addr)
                bfl_pkg::ADDR_SINK_EN: sink_en_q <= wr_data[SINKS-1:0];
                bfl_pkg::ADDR_MAIN_CUR: main_target_q <= wr_data[CODE_W-1:0];
                bfl_pkg::ADDR_SUB_CUR: sub_target_q <= wr_data[CODE_W-1:0];
                bfl_pkg::ADDR_REG_TWO: reg_two_q <= wr_data[bfl_pkg::REG_TWO_W-1:0];
                bfl_pkg::ADDR_REG_THREE: reg_three_q <= wr_data[bfl_pkg::REG_WIDE_W-1:0];
                bfl_pkg::ADDR_REG_FOUR: reg_four_q <= wr_data[bfl_pkg::REG_WIDE_W-1:0];
                bfl_pkg::ADDR_FADE: begin
                    main_ramp_enable <= wr_data[bfl_pkg::FADE_MAIN_EN_BIT];
                    main_ramp_rate <= wr_data[bfl_pkg::FADE_MAIN_RATE_LSB +: bfl_pkg::RATE_W];
                    sub_ramp_enable <= wr_data[bfl_pkg::FADE_SUB_EN_BIT];
                    sub_ramp_rate <= wr_data[bfl_pkg::FADE_SUB_RATE_LSB +: bfl_pkg::RATE_W];
                end
                bfl_pkg::ADDR_GROUP: group_code_q <= wr_data[bfl_pkg::GROUP_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // enable pin synchroniser, change taken once stages two and three agree
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;
    logic pin_level_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            pin_level_q <= 1'b0;
        end else begin
            pin_s1_q <= reg_four_enable_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            if (pin_s2_q == pin_s3_q) begin
                pin_level_q <= pin_s3_q;
            end
        end
    end

    // regulator code decode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regulator_two_mv <= bfl_pkg::MV_OFF;
            regulator_three_mv <= bfl_pkg::MV_OFF;
            regulator_four_mv <= bfl_pkg::MV_OFF;
        end else begin
            regulator_two_mv <= bfl_pkg::two_mv(reg_two_q);
            regulator_three_mv <= bfl_pkg::wide_mv(reg_three_q);
            regulator_four_mv <= pin_level_q ? bfl_pkg::wide_mv(reg_four_q)
                : bfl_pkg::MV_OFF;
        end
    end

    // millisecond tick
    logic [PRE_W-1:0] pre_q;
    logic ms_tick;
    assign ms_tick = (pre_q == PRE_LAST);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
        end else if (ms_tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // one ramp engine per group: 0 main, 1 sub
    logic [1:0] g_en;
    logic [1:0][bfl_pkg::RATE_W-1:0] g_rate;
    logic [1:0][CODE_W-1:0] g_target;
    logic [1:0][CODE_W-1:0] g_applied_q;
    logic [1:0] g_busy;
    assign g_en = {sub_ramp_enable, main_ramp_enable};
    assign g_rate = {sub_ramp_rate, main_ramp_rate};
    assign g_target = {sub_target_q, main_target_q};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_ramp
            logic [TMR_W-1:0] tmr_q;
            logic [TMR_W-1:0] interval;
            logic [CODE_W-1:0] applied_q;
            logic step_due;
            assign interval = bfl_pkg::rate_ms(g_rate[g]);
            assign g_applied_q[g] = applied_q;
            assign g_busy[g] = (applied_q != g_target[g]);
            assign step_due = ms_tick && (tmr_q >= interval - 1'b1);
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    applied_q <= '0;
                end else if (!g_en[g]) begin
                    applied_q <= g_target[g];
                end else if (g_busy[g] && step_due) begin
                    if (applied_q < g_target[g]) begin
                        applied_q <= applied_q + 1'b1;
                    end else begin
                        applied_q <= applied_q - 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    tmr_q <= '0;
                end else if (!g_en[g] || !g_busy[g] || step_due) begin
                    tmr_q <= '0;
                end else if (ms_tick) begin
                    tmr_q <= tmr_q + 1'b1;
                end
            end
        end
    endgenerate

    assign main_ramp_busy = g_busy[0];
    assign sub_ramp_busy = g_busy[1];
    assign main_current_code = g_applied_q[0];
    assign sub_current_code = g_applied_q[1];

    // sink mapping
    logic [SINKS-1:0] mask;
    assign mask = bfl_pkg::main_mask(group_code_q);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sink_on <= '0;
            sink_in_main <= '0;
            sink_code <= '0;
        end else begin
            sink_on <= sink_en_q;
            sink_in_main <= mask;
            for (int i = 0; i < SINKS; i++) begin
                sink_code[i*CODE_W +: CODE_W] <= mask[i] ? g_applied_q[0]
                    : g_applied_q[1];
            end
        end
    end
endmodule
`default_nettype wire

//--- src/bfl_pkg.sv
// shared constants for the backlight fade, sink group and regulator register bank
package bfl_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 6;
    localparam int CODE_W = 5;
    localparam int SINKS = 5;
    localparam int MV_W = 12;
    localparam int RATE_W = 2;
    localparam int TMR_W = 6;

    localparam logic [ADDR_W-1:0] ADDR_SINK_EN = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MAIN_CUR = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_SUB_CUR = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_REG_TWO = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_REG_THREE = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_REG_FOUR = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_FADE = 4'h9;
    localparam logic [ADDR_W-1:0] ADDR_GROUP = 4'ha;

    // field positions of the fade control register
    localparam int FADE_MAIN_EN_BIT = 0;
    localparam int FADE_MAIN_RATE_LSB = 1;
    localparam int FADE_SUB_EN_BIT = 3;
    localparam int FADE_SUB_RATE_LSB = 4;
    localparam int REG_TWO_W = 3;
    localparam int REG_WIDE_W = 4;
    localparam int GROUP_W = 3;

    localparam logic [DATA_W-1:0] RESET_VALUE = 6'h00;

    // timebase
    localparam int CLK_HZ = 40_000_000;
    localparam int STEP_UNIT_MS = 1;
    localparam int MS_CYCLES = CLK_HZ / 1000 * STEP_UNIT_MS;

    localparam logic [TMR_W-1:0] RATE0_MS = 6'h20;
    localparam logic [TMR_W-1:0] RATE1_MS = 6'h18;
    localparam logic [TMR_W-1:0] RATE2_MS = 6'h10;
    localparam logic [TMR_W-1:0] RATE3_MS = 6'h08;

    // regulator millivolt figures
    localparam logic [MV_W-1:0] MV_OFF = 12'h000;
    localparam logic [MV_W-1:0] MV_STEP = 12'h064;
    localparam logic [MV_W-1:0] MV_TWO_TOP = 12'h708;
    localparam logic [MV_W-1:0] MV_WIDE_TOP = 12'hce4;
    localparam logic [MV_W-1:0] MV_WIDE_LOW_2V2 = 12'h898;
    localparam logic [MV_W-1:0] MV_WIDE_BOT_TOP = 12'h708;
    localparam logic [REG_WIDE_W-1:0] WIDE_2V2_CODE = 4'hb;
    localparam logic [REG_WIDE_W-1:0] WIDE_BOT_CODE = 4'hc;

    function automatic logic [MV_W-1:0] two_mv(input logic [REG_TWO_W-1:0] c);
        two_mv = (c == 3'h0) ? MV_OFF :
            MV_TWO_TOP - MV_STEP * {9'h000, c - 3'h1};
    endfunction

    function automatic logic [MV_W-1:0] wide_mv(input logic [REG_WIDE_W-1:0] c);
        if (c == 4'h0) begin
            wide_mv = MV_OFF;
        end else if (c < WIDE_2V2_CODE) begin
            wide_mv = MV_WIDE_TOP - MV_STEP * {8'h00, c - 4'h1};
        end else if (c == WIDE_2V2_CODE) begin
            wide_mv = MV_WIDE_LOW_2V2;
        end else begin
            wide_mv = MV_WIDE_BOT_TOP - MV_STEP * {8'h00, c - WIDE_BOT_CODE};
        end
    endfunction

    function automatic logic [TMR_W-1:0] rate_ms(input logic [RATE_W-1:0] r);
        case (r)
            2'h0: rate_ms = RATE0_MS;
            2'h1: rate_ms = RATE1_MS;
            2'h2: rate_ms = RATE2_MS;
            default: rate_ms = RATE3_MS;
        endcase
    endfunction

    // main sink mask per group code; unlisted codes keep all five in main
    function automatic logic [SINKS-1:0] main_mask(input logic [GROUP_W-1:0] g);
        case (g)
            3'h1: main_mask = 5'h1f;
            3'h2: main_mask = 5'h0f;
            3'h3: main_mask = 5'h07;
            3'h4: main_mask = 5'h03;
            3'h5: main_mask = 5'h01;
            default: main_mask = 5'h1f;
        endcase
    endfunction
endpackage
